// ---- verilog/fpp_top.sv ----
// Pointer-based write protection logic of a serial flash device
`timescale 1ns/1ps
module fpp_top
    import fpp_pkg::*;
#(
    parameter bit DENSITY_64 = 1'b1,
    parameter int NV_CYCLES  = NV_WRITE_CYC
) (
    input  wire logic        sys_clk,
    input  wire logic        arst_n,
    input  wire logic        link_clk,
    input  wire logic        chip_sel_n,
    input  wire logic        serial_in,
    output logic             serial_out,
    output logic             serial_out_oe_n,
    input  wire logic        write_protect_n,
    input  wire logic        write_enable_set,
    input  wire logic        write_enable_clear,
    input  wire logic        suspended,
    input  wire logic        status_load,
    input  wire logic [7:0]  status_one_in,
    input  wire logic [7:0]  status_two_in,
    input  wire logic [23:0] check_addr,
    output logic             addr_protected,
    output logic             block_erase_reject,
    output logic             block_scheme,
    output logic             write_enable_latch,
    output logic             busy,
    output logic [7:0]       status_reg_one,
    output logic [7:0]       status_reg_two,
    output logic [7:0]       status_reg_three,
    output logic [15:0]      pe_cycle_count
);
    // ****************************************************************
    // Link domain: frame capture
    // ****************************************************************
    logic        frame_rst;
    logic [5:0]  bit_cnt;
    logic [7:0]  op_shift;
    logic [23:0] addr_shift;
    logic [23:0] readback;
    logic [5:0]  out_idx;
    logic [23:0] shadow;
    logic        frame_full;

    // Frame counters restart whenever chip select is high. The select
    // pin doubles as an asynchronous clear because the link clock is
    // parked between frames, so no edge exists to clear them with.
    assign frame_rst = !arst_n || chip_sel_n;

    always_ff @(posedge link_clk or posedge frame_rst) begin
        if (frame_rst) begin
            bit_cnt <= 6'h00;
        end else if (bit_cnt != 6'h3F) begin
            bit_cnt <= bit_cnt + 6'h01;  // Saturates past the frame
        end
    end

    // length of the frame just ended
    // Set only when the last rising edge was the 32nd of the frame, so a
    // short frame or one with extra bits leaves it low. Only the global
    // reset clears it: the select release that ends the frame must not
    // wipe it before the system side has looked at it.
    // Limitation: a select pulse with no clock edges keeps the old value.
    always_ff @(posedge link_clk or negedge arst_n) begin
        if (!arst_n) begin
            frame_full <= 1'b0;
        end else begin
            frame_full <= bit_cnt == FRAME_BITS - 6'h01;
        end
    end

    // Opcode and address shift in MSB first
    always_ff @(posedge link_clk or negedge arst_n) begin
        if (!arst_n) begin
            op_shift   <= 8'h00;
            addr_shift <= 24'h000000;
        end else if (bit_cnt < OPCODE_BITS) begin
            op_shift <= {op_shift[6:0], serial_in};
        end else if (bit_cnt < FRAME_BITS) begin
            addr_shift <= {addr_shift[22:0], serial_in};
        end
    end

    // output byte order, then erased filler
    assign out_idx = bit_cnt - OPCODE_BITS;
    always_ff @(negedge link_clk or posedge frame_rst) begin
        if (frame_rst) begin
            serial_out      <= 1'b0;
            serial_out_oe_n <= 1'b1;
        end else if (op_shift == OP_READ_STAT3 && bit_cnt >= OPCODE_BITS) begin
            serial_out_oe_n <= 1'b0;
            if (out_idx < 6'h18) begin
                serial_out <= readback[5'h17 - out_idx[4:0]];
            end else begin
                serial_out <= ERASED_BYTE[3'h7 - out_idx[2:0]];
            end
        end
    end
    // The shadow freezes two system cycles after select falls, long
    // before the eighth falling edge first reads it, so this crossing
    // needs no handshake unless the link runs far faster than sys_clk
    assign readback = shadow;

    // ****************************************************************
    // Crossing into the system domain
    // ****************************************************************
    // Only the select and write protect pins cross as live signals. The
    // captured opcode and address cross as data, sampled once the
    // synchronised select has risen; the readback shadow crosses the
    // other way and is only rewritten while select is high.
    logic cs_meta;
    logic cs_sync;
    logic cs_prev;
    logic wp_meta;
    logic wp_sync;
    logic frame_end;

    // Two-flop synchronisers for chip select and write protect pin
    // The third select flop only feeds the edge detector; reset values
    // match the idle high level so no false frame end follows reset.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            cs_meta <= 1'b1;
            cs_sync <= 1'b1;
            cs_prev <= 1'b1;
            wp_meta <= 1'b1;
            wp_sync <= 1'b1;
        end else begin
            cs_meta <= chip_sel_n;
            cs_sync <= cs_meta;
            cs_prev <= cs_sync;
            wp_meta <= write_protect_n;
            wp_sync <= wp_meta;
        end
    end
    // Opcode, address and length flag only change on link edges, and the
    // link clock is parked while select is high, so once the synchronised
    // select rises they are steady and safe to sample here. The bit
    // counter is not among them: select high clears it at once.
    assign frame_end = cs_sync && !cs_prev;

    // ****************************************************************
    // Status registers and write enable latch
    // ****************************************************************
    logic guard_locked;
    logic accept;
    logic nv_done;
    fpp_state_t state;
    logic [$clog2(NV_CYCLES+1)-1:0] nv_cnt;

    // delivery values of the status registers
    // Loads are refused while locked or busy, like the command path
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            status_reg_one   <= SR1_RESET;
            status_reg_two   <= SR2_RESET;
            status_reg_three <= SR3_RESET;
        end else if (status_load && !guard_locked && state == FPP_IDLE) begin
            status_reg_one <= status_one_in;
            status_reg_two <= status_two_in;
        end
    end

    // guard bits lock like the status registers
    assign guard_locked = status_reg_two[GUARD_HIGH_POS]
                       || (status_reg_one[GUARD_LOW_POS] && !wp_sync);

    assign accept = frame_end && op_shift == OP_SET_PROTECT
                 && frame_full && write_enable_latch
                 && !guard_locked && !suspended && state == FPP_IDLE;

    // latch cleared when the update ends
    // Clearing wins over setting, so a set in the last busy cycle
    // cannot leave the latch armed after the update.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            write_enable_latch <= 1'b0;
        end else if (nv_done || write_enable_clear) begin
            write_enable_latch <= 1'b0;
        end else if (write_enable_set && state == FPP_IDLE) begin
            write_enable_latch <= 1'b1;
        end
    end

    // ****************************************************************
    // Self-timed non-volatile update
    // ****************************************************************
    // The accepted value waits in the pending set for the whole write
    // time and lands in the stored set when the counter runs out, so a
    // query during the update still sees the old protection.
    logic        ptr_block;
    logic        ptr_all;
    logic [10:0] ptr_sector;
    logic        next_block;
    logic        next_all;
    logic [10:0] next_sector;
    logic        pend_block;
    logic        pend_all;
    logic [10:0] pend_sector;

    // decode the captured address
    // Protect-all and the block scheme store a zero sector, so readback
    // of those settings never echoes the ignored address bits.
    always_comb begin
        next_block  = addr_shift[SCHEME_POS];
        next_all    = 1'b0;
        next_sector = 11'h000;
        if (!next_block) begin
            next_all = addr_shift[ALL_POS];
            if (!next_all) begin
                next_sector = DENSITY_64
                    ? addr_shift[PTR_MSB_64M:PTR_LSB]
                    : {1'b0, addr_shift[PTR_MSB_32M:PTR_LSB]};
            end
        end
    end

    // busy for the whole write time
    // The counter is loaded with one less than the write time because
    // the cycle that sees zero is still a busy cycle; the latch clear
    // and the pointer update land on that same edge.
    assign nv_done = state == FPP_BUSY && nv_cnt == '0;
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state  <= FPP_IDLE;
            nv_cnt <= '0;
        end else begin
            unique case (state)
                FPP_IDLE: begin
                    if (accept) begin
                        state  <= FPP_BUSY;
                        nv_cnt <= ($clog2(NV_CYCLES+1))'(NV_CYCLES - 1);
                    end
                end
                FPP_BUSY: begin
                    if (nv_cnt == '0) begin
                        state <= FPP_IDLE;
                    end else begin
                        nv_cnt <= nv_cnt - 1'b1;
                    end
                end
            endcase
        end
    end
    assign busy = state == FPP_BUSY;

    // Pending value is held through the busy time
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            pend_block  <= 1'b1;
            pend_all    <= 1'b0;
            pend_sector <= 11'h000;
        end else if (accept) begin
            pend_block  <= next_block;
            pend_all    <= next_all;
            pend_sector <= next_sector;
        end
    end

    // one stored scheme flag, block scheme by default
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ptr_block  <= 1'b1;
            ptr_all    <= 1'b0;
            ptr_sector <= 11'h000;
        end else if (nv_done) begin
            ptr_block  <= pend_block;
            ptr_all    <= pend_all;
            ptr_sector <= pend_sector;
        end
    end

    // count an array cycle only for a changed value
    // An unchanged rewrite still runs the full busy time and clears the
    // latch, but the register array is not cycled.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            pe_cycle_count <= 16'h0000;
        end else if (nv_done && {pend_block, pend_all, pend_sector}
                     != {ptr_block, ptr_all, ptr_sector}) begin
            pe_cycle_count <= pe_cycle_count + 16'h0001;
        end
    end

    // Readback image, refreshed only while the synchronised select is
    // high. The pointer bytes mirror address bits 23 to 8 of the set
    // frame: a zero top bit, the sector, protect-all, scheme and two
    // unused bits. Only the synchronised select is read, never the raw
    // pin, so a select edge near the clock cannot split the update.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            shadow <= {SR3_RESET, 16'h0004};
        end else if (cs_sync) begin
            shadow <= {status_reg_three, 1'b0, ptr_sector, ptr_all,
                       ptr_block, 2'h0};
        end
    end

    // ****************************************************************
    // Protection decision for a queried address
    // ****************************************************************
    // The query port stands for the erase and program paths. Address
    // bits above the array size are masked first, so an address past
    // the top wraps the way the array decoder does.
    logic [23:0] lim_addr;
    logic [10:0] q_sector;
    logic        tb;
    logic        q_prot;
    logic        q_blk_hit;
    logic        q_reject;

    // query address folded into the array size
    assign lim_addr = check_addr & (DENSITY_64 ? AMAX_64M : AMAX_32M);
    assign q_sector = lim_addr[PTR_MSB_64M:PTR_LSB];
    assign tb       = status_reg_one[TB_POS];

    // unprotected side of the pointer
    // Outside protect-all the pointer sector never compares as protected,
    // whatever the select bit, so it then lies on the unprotected side.
    always_comb begin
        q_prot = 1'b0;
        if (!ptr_block) begin
            if (ptr_all) begin
                q_prot = 1'b1;
            end else if (!tb) begin
                q_prot = q_sector > ptr_sector;
            end else begin
                q_prot = q_sector < ptr_sector;
            end
        end
    end

    // erase of the pointer block, with the two exceptions
    // A block is sixteen sectors sharing sector bits 10 to 4; outside
    // the pointer block an erase simply follows the protection answer.
    assign q_blk_hit = q_sector[10:4] == ptr_sector[10:4];
    always_comb begin
        q_reject = 1'b0;
        if (!ptr_block) begin
            if (ptr_all) begin
                q_reject = 1'b1;
            end else if (q_blk_hit) begin
                q_reject = !((!tb && ptr_sector[3:0] == BLK_TOP_SECTOR)
                          || (tb && ptr_sector[3:0] == BLK_BOT_SECTOR));
            end else begin
                q_reject = q_prot;
            end
        end
    end

    // Query answers are registered, one cycle after the address
    // Registering keeps the long compare chains off the outputs, at the
    // cost of one cycle of latency on every query.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            addr_protected     <= 1'b0;
            block_erase_reject <= 1'b0;
            block_scheme       <= 1'b1;
        end else begin
            addr_protected     <= q_prot;
            block_erase_reject <= q_reject;
            block_scheme       <= ptr_block;
        end
    end
endmodule

// ---- include/fpp_pkg.sv ----
// Constants for the flash pointer protection block
package fpp_pkg;
    // ****************************************************************
    // Opcodes and frame layout
    // ****************************************************************
    localparam logic [7:0] OP_SET_PROTECT  = 8'h39;
    localparam logic [7:0] OP_READ_STAT3   = 8'h33;
    localparam logic [5:0] FRAME_BITS      = 6'h20;
    localparam logic [5:0] OPCODE_BITS     = 6'h08;
    localparam int         SCHEME_POS      = 10;
    localparam int         ALL_POS         = 11;
    localparam int         PTR_LSB         = 12;
    localparam int         PTR_MSB_32M     = 21;
    localparam int         PTR_MSB_64M     = 22;
    localparam int         TB_POS          = 5;
    localparam int         GUARD_LOW_POS   = 7;
    localparam int         GUARD_HIGH_POS  = 0;
    // ****************************************************************
    // Limits and delivery values
    // ****************************************************************
    localparam logic [23:0] AMAX_64M       = 24'h7FFFFF;
    localparam logic [23:0] AMAX_32M       = 24'h3FFFFF;
    localparam logic [7:0]  ERASED_BYTE    = 8'hFF;
    localparam logic [7:0]  SR1_RESET      = 8'h00;
    localparam logic [7:0]  SR2_RESET      = 8'h04;
    localparam logic [7:0]  SR3_RESET      = 8'h70;
    localparam logic [3:0]  BLK_TOP_SECTOR = 4'hF;
    localparam logic [3:0]  BLK_BOT_SECTOR = 4'h0;
    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int SYS_CLK_MHZ   = 100;
    localparam int NV_WRITE_US   = 10;
    localparam int NV_WRITE_CYC  = NV_WRITE_US * SYS_CLK_MHZ;
    typedef enum logic [1:0] {FPP_IDLE, FPP_BUSY} fpp_state_t;
endpackage

// ---- test/fpp_checker_sva.sv ----
// Concurrent checks on the flash pointer protection block ports
`timescale 1ns/1ps
module fpp_checker
    import fpp_pkg::*;
#(
    parameter int NV_CYCLES = NV_WRITE_CYC
) (
    input wire logic        sys_clk,
    input wire logic        arst_n,
    input wire logic        chip_sel_n,
    input wire logic        suspended,
    input wire logic        addr_protected,
    input wire logic        block_scheme,
    input wire logic        write_enable_latch,
    input wire logic        busy,
    input wire logic [7:0]  status_reg_two,
    input wire logic [15:0] pe_cycle_count
);
    // ************************************************************
    // Helper logic and checks
    // ************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    logic [15:0] busy_len;

    // Length of the running update, cleared when idle
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            busy_len <= 16'h0000;
        end else if (busy) begin
            busy_len <= busy_len + 16'h0001;
        end else begin
            busy_len <= 16'h0000;
        end
    end

    busy_len_a: assert property (
        $fell(busy) |-> busy_len == 16'(NV_CYCLES))
        else $error("update length differs from NV_CYCLES");
    latch_clear_a: assert property (
        $fell(busy) |-> !write_enable_latch)
        else $error("latch still set after update");
    busy_hold_a: assert property (
        $rose(busy) |=> busy [*8])
        else $error("busy dropped early");
    needs_latch_a: assert property (
        $rose(busy) |-> $past(write_enable_latch))
        else $error("update started without latch");
    no_suspend_a: assert property (
        $rose(busy) |-> !$past(suspended))
        else $error("update started while suspended");
    guard_lock_a: assert property (
        $rose(busy) |-> !$past(status_reg_two[0]))
        else $error("update started under guard lock");
    frame_end_a: assert property (
        $rose(busy) |-> chip_sel_n && $past(chip_sel_n, 2))
        else $error("update started inside a frame");
    one_scheme_a: assert property (
        block_scheme && $past(block_scheme) |-> !addr_protected)
        else $error("pointer protection seen in block scheme");
    pe_step_a: assert property (
        $changed(pe_cycle_count) |->
            pe_cycle_count == $past(pe_cycle_count) + 16'h0001)
        else $error("cycle count moved by more than one");
endmodule

bind fpp_top fpp_checker #(.NV_CYCLES(NV_CYCLES)) fpp_checker_i (
    .sys_clk, .arst_n, .chip_sel_n, .suspended, .addr_protected,
    .block_scheme, .write_enable_latch, .busy, .status_reg_two,
    .pe_cycle_count);

// ---- test/fpp_host_model.sv ----
// Host serial controller model for the protection block link
`timescale 1ns/1ps
module fpp_host_model (
    output logic      link_clk,
    output logic      chip_sel_n,
    output logic      serial_in,
    input  wire logic serial_out,
    input  wire logic serial_out_oe_n
);
    localparam int HALF_NS = 16;

    // Clock parked low and select high outside frames
    initial begin
        link_clk = 1'b0;
        chip_sel_n = 1'b1;
        serial_in = 1'b0;
    end

    task automatic frame(input logic [31:0] word, input int nbits,
                         output logic [31:0] rd);
        rd = 32'h0000_0000;
        chip_sel_n = 1'b0;
        for (int i = 31; i > 31 - nbits; i--) begin
            serial_in = word[i];
            #HALF_NS;
            // Undriven line reads as unknown so it never matches
            rd = {rd[30:0], serial_out_oe_n ? 1'bx : serial_out};
            link_clk = 1'b1;
            #HALF_NS link_clk = 1'b0;
        end
        #HALF_NS chip_sel_n = 1'b1;
        // Released line must not keep its last value
        serial_in = ~serial_in;
    endtask
endmodule

// ---- test/flash_pointer_protection_bench.sv ----
// Self-checking bench for the flash pointer protection block
`timescale 1ns/1ps
module flash_pointer_protection_bench;
    import fpp_pkg::*;
    localparam int NV = 20;
    logic        sys_clk, arst_n, link_clk, chip_sel_n, serial_in;
    logic        serial_out, serial_out_oe_n, write_protect_n, suspended;
    logic        write_enable_set, write_enable_clear, status_load;
    logic [7:0]  status_one_in, status_two_in;
    logic [7:0]  status_reg_one, status_reg_two, status_reg_three;
    logic [23:0] check_addr;
    logic        addr_protected, block_erase_reject, block_scheme;
    logic        write_enable_latch, busy;
    logic [15:0] pe_cycle_count;
    logic [31:0] rd;
    int          bad_count, cmp_count;

    fpp_top #(.DENSITY_64(1'b1), .NV_CYCLES(NV)) fpp_top_i (
        .sys_clk, .arst_n, .link_clk, .chip_sel_n, .serial_in, .serial_out,
        .serial_out_oe_n, .write_protect_n, .write_enable_set,
        .write_enable_clear, .suspended, .status_load, .status_one_in,
        .status_two_in, .check_addr, .addr_protected, .block_erase_reject,
        .block_scheme, .write_enable_latch, .busy, .status_reg_one,
        .status_reg_two, .status_reg_three, .pe_cycle_count);
    fpp_host_model fpp_host_model_i (.link_clk, .chip_sel_n, .serial_in,
        .serial_out, .serial_out_oe_n);

    // System clock, 10 ns period
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic chk(input string nm, input logic [23:0] e, g);
        cmp_count++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic we();
        write_enable_set = 1'b1;
        tick(1);
        write_enable_set = 1'b0;
        tick(1);
    endtask
    task automatic load(input logic [7:0] a, b);
        status_one_in = a;
        status_two_in = b;
        status_load = 1'b1;
        tick(1);
        status_load = 1'b0;
        tick(1);
    endtask
    // Busy must appear within a few cycles only when accepted
    task automatic setp(input logic [23:0] a, input int n, input logic eb);
        logic seen;
        seen = 1'b0;
        fpp_host_model_i.frame({OP_SET_PROTECT, a}, n, rd);
        repeat (10) begin
            tick(1);
            if (busy === 1'b1) seen = 1'b1;
        end
        chk("busy", 24'(eb), 24'(seen));
        repeat (NV + 10) if (busy === 1'b1) tick(1);
        tick(2);
    endtask
    task automatic rdback(input logic [23:0] e);
        fpp_host_model_i.frame({OP_READ_STAT3, 24'h0}, 32, rd);
        tick(5);
        chk("readback", e, rd[23:0]);
    endtask
    task automatic q(input logic [23:0] a, input logic p, r);
        check_addr = a;
        tick(2);
        chk("protected", 24'(p), 24'(addr_protected));
        chk("reject", 24'(r), 24'(block_erase_reject));
    endtask
    task automatic results();
        $display("compares %0d errors %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // Watchdog well beyond the expected run of about 16 us
    initial begin
        #400000;
        bad_count++;
        results();
    end

    // ************************************************************
    // Test sequence
    // ************************************************************
    initial begin
        arst_n = 1'b0; write_protect_n = 1'b1; suspended = 1'b0;
        write_enable_set = 1'b0; write_enable_clear = 1'b0;
        status_load = 1'b0; status_one_in = 8'h00; status_two_in = 8'h04;
        check_addr = 24'h000000; bad_count = 0; cmp_count = 0;
        repeat (3) @(posedge sys_clk);
        #1 arst_n = 1'b1;
        tick(3);
        chk("status one", 24'h000000, 24'(status_reg_one));
        chk("status two", 24'h000004, 24'(status_reg_two));
        chk("status three", 24'h000070, 24'(status_reg_three));
        chk("scheme", 24'h000001, 24'(block_scheme));
        rdback(24'h700004);
        setp(24'h123000, 32, 1'b0);
        we();
        setp(24'h9233FF, 32, 1'b1);
        chk("latch", 24'h000000, 24'(write_enable_latch));
        chk("scheme", 24'h000000, 24'(block_scheme));
        chk("count", 24'h000001, 24'(pe_cycle_count));
        q(24'h123456, 1'b0, 1'b1);
        q(24'h000000, 1'b0, 1'b0);
        q(24'h124000, 1'b1, 1'b1);
        q(24'h7FFFFF, 1'b1, 1'b1);
        rdback(24'h701230);
        we();
        setp(24'h123000, 32, 1'b1);
        chk("count", 24'h000001, 24'(pe_cycle_count));
        load(8'h20, 8'h04);
        chk("status one", 24'h000020, 24'(status_reg_one));
        we();
        setp(24'h120000, 32, 1'b1);
        q(24'h120000, 1'b0, 1'b0);
        q(24'h11F000, 1'b1, 1'b1);
        q(24'h7FFFFF, 1'b0, 1'b0);
        load(8'h00, 8'h04);
        we();
        setp(24'h12F000, 32, 1'b1);
        q(24'h12F000, 1'b0, 1'b0);
        we();
        setp(24'h7FF800, 32, 1'b1);
        q(24'h000000, 1'b1, 1'b1);
        rdback(24'h700008);
        we();
        suspended = 1'b1;
        setp(24'h000000, 32, 1'b0);
        suspended = 1'b0;
        setp(24'h000400, 31, 1'b0);
        setp(24'h000400, 32, 1'b1);
        chk("scheme", 24'h000001, 24'(block_scheme));
        q(24'h000000, 1'b0, 1'b0);
        we();
        write_enable_clear = 1'b1;
        tick(1);
        write_enable_clear = 1'b0;
        tick(1);
        chk("latch", 24'h000000, 24'(write_enable_latch));
        load(8'h00, 8'h05);
        we();
        setp(24'h000000, 32, 1'b0);
        results();
    end
endmodule
